// [src/addr_reg_modify_unit.v]
// address-phase arithmetic on auxiliary, temporary and extended addressing registers
// assumes decoded instruction words from the pipeline on CLK and software access over axi4-lite
`include "addr_modify_regs.vh"
`default_nettype none
module addr_reg_modify_unit (
    input  wire        CLK,
    input  wire        ARST_N,
    input  wire        INSTR_VALID,
    input  wire [23:0] INSTR,
    input  wire        CIRC_QUAL,
    output reg         OP_DONE,
    output reg         OP_ILLEGAL,
    output wire        DMEM_REQ,
    input  wire [7:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output wire        S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output wire        S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [7:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output wire        S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY
);
    reg  [22:0] ext_reg [0:`EXT_REG_COUNT-1];
    reg  [15:0] tmp_reg [0:3];
    reg  [7:0]  status_reg_two;
    reg  [15:0] circ_size_reg_low;
    reg  [15:0] circ_size_reg_high;
    reg  [1:0]  control_reg;
    reg  [22:0] last_result_reg;
    reg         aw_full_reg;
    reg         w_full_reg;
    reg  [7:0]  aw_addr_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    integer     i;

    // circular step inside a buffer [0, size); size zero means linear
    function [15:0] circ_step;
        input [15:0] ptr;
        input [15:0] delta;
        input        neg;
        input        circ;
        input [15:0] size;
        reg   [16:0] sum;
        begin
            sum = neg ? ({1'b0, ptr} - {1'b0, delta}) : ({1'b0, ptr} + {1'b0, delta});
            circ_step = sum[15:0];
            if (circ && size != 16'h0000) begin
                if (neg && ptr < delta)
                    circ_step = sum[15:0] + size;
                else if (!neg && sum >= {1'b0, size})
                    circ_step = sum[15:0] - size;
            end
        end
    endfunction

    function [15:0] pick_size;
        input [2:0]  arn;
        input        legacy;
        input [15:0] low;
        input [15:0] high;
        begin
            pick_size = (legacy || !arn[2]) ? low : high;
        end
    endfunction

    function [31:0] merge_bytes;
        input [31:0] old;
        input [31:0] wdat;
        input [3:0]  strb;
        integer      b;
        begin
            merge_bytes = old;
            for (b = 0; b < 4; b = b + 1)
                if (strb[b])
                    merge_bytes[b*8 +: 8] = wdat[b*8 +: 8];
        end
    endfunction

    function [31:0] reg_read;
        input [7:0] addr;
        begin
            reg_read = 32'h00000000;
            if (addr < `ADDR_TMP_BASE)
                reg_read = {9'h000, ext_reg[addr[5:2]]};
            else if (addr < `ADDR_STATUS_TWO)
                reg_read = {16'h0000, tmp_reg[addr[3:2]]};
            else if (addr == `ADDR_STATUS_TWO)
                reg_read = {24'h000000, status_reg_two};
            else if (addr == `ADDR_CIRC_LOW)
                reg_read = {16'h0000, circ_size_reg_low};
            else if (addr == `ADDR_CIRC_HIGH)
                reg_read = {16'h0000, circ_size_reg_high};
            else if (addr == `ADDR_CONTROL)
                reg_read = {30'h00000000, control_reg};
            else if (addr == `ADDR_LAST_RESULT)
                reg_read = {9'h000, last_result_reg};
        end
    endfunction

    function addr_mapped;
        input [7:0] addr;
        begin
            addr_mapped = (addr[1:0] == 2'b00) && (addr <= `ADDR_LAST_RESULT);
        end
    endfunction

    // instruction decode
    wire        legacy_compat_mode = control_reg[`CTRL_LEGACY_BIT];
    wire        stack_32bit        = control_reg[`CTRL_STACK32_BIT];
    wire        is_modify_hi       = INSTR[23:17] == `OPC_MODIFY_HI;
    wire        is_ext_form        = INSTR[11:8] == `OPC_EXT_MID;
    wire        op_subp8 = INSTR_VALID && is_modify_hi && INSTR[2:0] == `OPC_SUBP8_LO;
    wire        op_xadd  = INSTR_VALID && is_modify_hi && is_ext_form && INSTR[2:0] == `OPC_EXT_ADD_LO;
    wire        op_xsub  = INSTR_VALID && is_modify_hi && is_ext_form && INSTR[2:0] == `OPC_EXT_SUB_LO;
    wire        op_xmov  = INSTR_VALID && (is_modify_hi || INSTR[23:17] == `OPC_MOVE_Y_HI) && is_ext_form
                           && INSTR[2:0] == `OPC_EXT_MOV_LO;
    wire        op_stack = INSTR_VALID && INSTR[23:17] == `OPC_STACK_HI;
    wire        op_lea   = INSTR_VALID && INSTR[23:16] == `OPC_LEA_HI && INSTR[3:0] == `OPC_LEA_LO;
    wire [7:0]  prog_addr_imm8 = INSTR[15:8];
    wire [7:0]  signed_imm8    = INSTR[15:8];
    wire [3:0]  ext_src_reg    = INSTR[15:12];
    wire [3:0]  ext_dest_reg   = INSTR[7:4];
    wire [2:0]  dst_arn        = INSTR[6:4];
    wire [2:0]  lea_arn        = INSTR[15:13];
    wire [3:0]  lea_mode       = INSTR[12:9];

    reg         ext_we;
    reg  [3:0]  ext_widx;
    reg  [22:0] ext_wval;
    reg         ssp_we;
    reg  [22:0] ssp_wval;
    reg         tmp_we;
    reg  [1:0]  tmp_widx;
    reg  [15:0] tmp_wval;
    reg         illegal;
    reg  [15:0] offset;
    reg  [15:0] ptr16;
    reg         circ_on;

    always @* begin
        ext_we   = 1'b0;
        ext_widx = 4'h0;
        ext_wval = 23'h000000;
        ssp_we   = 1'b0;
        ssp_wval = 23'h000000;
        tmp_we   = 1'b0;
        tmp_widx = 2'b00;
        tmp_wval = 16'h0000;
        illegal  = 1'b0;
        offset   = 16'h0000;
        ptr16    = 16'h0000;
        circ_on  = 1'b0;
        if (op_subp8) begin
            if (INSTR[7]) begin
                tmp_widx = dst_arn[1:0];
                tmp_wval = tmp_reg[dst_arn[1:0]] - {8'h00, prog_addr_imm8};
                tmp_we   = !dst_arn[2];
                illegal  = dst_arn[2];
            end else begin
                ptr16    = ext_reg[{1'b0, dst_arn}][15:0];
                circ_on  = status_reg_two[dst_arn] | CIRC_QUAL;
                ext_we   = 1'b1;
                ext_widx = {1'b0, dst_arn};
                ext_wval = {ext_reg[{1'b0, dst_arn}][22:16],
                            circ_step(ptr16, {8'h00, prog_addr_imm8}, 1'b1, circ_on,
                                      pick_size(dst_arn, legacy_compat_mode, circ_size_reg_low,
                                                circ_size_reg_high))};
            end
        end else if (op_stack) begin
            ext_we   = 1'b1;
            ext_widx = `EXT_IDX_DSP;
            ext_wval = {ext_reg[`EXT_IDX_DSP][22:16],
                        ext_reg[`EXT_IDX_DSP][15:0] + {{8{signed_imm8[7]}}, signed_imm8}};
            ssp_we   = stack_32bit;
            ssp_wval = {ext_reg[`EXT_IDX_SSP][22:16],
                        ext_reg[`EXT_IDX_SSP][15:0] + {{8{signed_imm8[7]}}, signed_imm8}};
        end else if (op_lea) begin
            ptr16 = ext_reg[{1'b0, lea_arn}][15:0];
            case (lea_mode)
                `LEA_MODE_PLAIN:  offset = 16'h0000;
                `LEA_MODE_OFS_T0: offset = tmp_reg[0];
                `LEA_MODE_OFS_T1: offset = tmp_reg[1];
                default:          offset = 16'h0000;
            endcase
            circ_on  = status_reg_two[lea_arn];
            illegal  = !(lea_mode == `LEA_MODE_PLAIN || lea_mode == `LEA_MODE_OFS_T0 ||
                         lea_mode == `LEA_MODE_OFS_T1) || ext_dest_reg >= `EXT_REG_COUNT;
            ext_we   = !illegal;
            ext_widx = ext_dest_reg;
            ext_wval = {ext_reg[{1'b0, lea_arn}][22:16],
                        circ_step(ptr16, offset, 1'b0, circ_on,
                                  pick_size(lea_arn, legacy_compat_mode, circ_size_reg_low,
                                            circ_size_reg_high))};
        end else if (op_xadd || op_xsub || op_xmov) begin
            illegal  = ext_src_reg >= `EXT_REG_COUNT || ext_dest_reg >= `EXT_REG_COUNT;
            ext_we   = !illegal;
            ext_widx = ext_dest_reg;
            if (op_xmov)
                ext_wval = ext_reg[ext_src_reg];
            else if (op_xadd)
                ext_wval = ext_reg[ext_dest_reg] + ext_reg[ext_src_reg];
            else
                ext_wval = ext_reg[ext_dest_reg] - ext_reg[ext_src_reg];
        end
    end

    assign DMEM_REQ = 1'b0;

    // axi4-lite handshakes
    wire        wr_fire   = aw_full_reg && w_full_reg && !S_AXI_BVALID;
    assign S_AXI_AWREADY = !aw_full_reg && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_full_reg && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    wire [31:0] wr_merged = merge_bytes(reg_read(aw_addr_reg), w_data_reg, w_strb_reg);

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (i = 0; i < `EXT_REG_COUNT; i = i + 1)
                ext_reg[i] <= 23'h000000;
            for (i = 0; i < 4; i = i + 1)
                tmp_reg[i] <= 16'h0000;
            status_reg_two     <= 8'h00;
            circ_size_reg_low  <= 16'h0000;
            circ_size_reg_high <= 16'h0000;
            control_reg        <= 2'b00;
            last_result_reg    <= 23'h000000;
            OP_DONE            <= 1'b0;
            OP_ILLEGAL         <= 1'b0;
            aw_full_reg        <= 1'b0;
            w_full_reg         <= 1'b0;
            aw_addr_reg        <= 8'h00;
            w_data_reg         <= 32'h00000000;
            w_strb_reg         <= 4'h0;
            S_AXI_BVALID       <= 1'b0;
            S_AXI_BRESP        <= `RESP_OKAY;
            S_AXI_RVALID       <= 1'b0;
            S_AXI_RRESP        <= `RESP_OKAY;
            S_AXI_RDATA        <= 32'h00000000;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_full_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= addr_mapped(aw_addr_reg) && aw_addr_reg != `ADDR_LAST_RESULT ?
                                `RESP_OKAY : `RESP_SLVERR;
                if (addr_mapped(aw_addr_reg)) begin
                    if (aw_addr_reg < `ADDR_TMP_BASE)
                        ext_reg[aw_addr_reg[5:2]] <= wr_merged[22:0];
                    else if (aw_addr_reg < `ADDR_STATUS_TWO)
                        tmp_reg[aw_addr_reg[3:2]] <= wr_merged[15:0];
                    else if (aw_addr_reg == `ADDR_STATUS_TWO)
                        status_reg_two <= wr_merged[7:0];
                    else if (aw_addr_reg == `ADDR_CIRC_LOW)
                        circ_size_reg_low <= wr_merged[15:0];
                    else if (aw_addr_reg == `ADDR_CIRC_HIGH)
                        circ_size_reg_high <= wr_merged[15:0];
                    else if (aw_addr_reg == `ADDR_CONTROL)
                        control_reg <= wr_merged[1:0];
                end
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= addr_mapped(S_AXI_ARADDR) ? reg_read(S_AXI_ARADDR) : 32'h00000000;
                S_AXI_RRESP  <= addr_mapped(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
            // pipeline updates land after bus writes so they win on a collision
            if (ext_we) begin
                ext_reg[ext_widx] <= ext_wval;
                last_result_reg   <= ext_wval;
            end
            if (ssp_we)
                ext_reg[`EXT_IDX_SSP] <= ssp_wval;
            if (tmp_we) begin
                tmp_reg[tmp_widx] <= tmp_wval;
                last_result_reg   <= {7'h00, tmp_wval};
            end
            OP_DONE    <= ext_we | tmp_we;
            OP_ILLEGAL <= illegal;
        end
    end
endmodule
`default_nettype wire

// [inc/addr_modify_regs.vh]
// constants for the address-phase register modify unit
// assumes a 32-bit axi4-lite register bus with byte addresses
`ifndef ADDR_MODIFY_REGS_VH
`define ADDR_MODIFY_REGS_VH
`define EXT_REG_COUNT     12
`define EXT_IDX_CDP       4'hb
`define EXT_IDX_DSP       4'h8
`define EXT_IDX_SSP       4'h9
`define ADDR_EXT_BASE     8'h00
`define ADDR_TMP_BASE     8'h30
`define ADDR_STATUS_TWO   8'h40
`define ADDR_CIRC_LOW     8'h44
`define ADDR_CIRC_HIGH    8'h48
`define ADDR_CONTROL      8'h4c
`define ADDR_LAST_RESULT  8'h50
`define CTRL_LEGACY_BIT   0
`define CTRL_STACK32_BIT  1
`define OPC_MODIFY_HI     7'h0a
`define OPC_MOVE_Y_HI     7'h02
`define OPC_STACK_HI      7'h27
`define OPC_LEA_HI        8'hec
`define OPC_LEA_LO        4'he
`define OPC_EXT_MID       4'h1
`define OPC_SUBP8_LO      3'h6
`define OPC_EXT_ADD_LO    3'h0
`define OPC_EXT_SUB_LO    3'h2
`define OPC_EXT_MOV_LO    3'h1
`define LEA_MODE_PLAIN    4'h0
`define LEA_MODE_OFS_T0   4'h1
`define LEA_MODE_OFS_T1   4'h2
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// [testbench/addr_reg_modify_unit_checker.sv]
// port checker for the address-phase modify unit
// assumes it is bound into addr_reg_modify_unit and sees only its ports
`default_nettype none
module addr_reg_modify_unit_checker (
    input wire logic        CLK,
    input wire logic        ARST_N,
    input wire logic        INSTR_VALID,
    input wire logic [23:0] INSTR,
    input wire logic        OP_DONE,
    input wire logic        OP_ILLEGAL,
    input wire logic        DMEM_REQ,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    wire       regs_ok = INSTR[15:12] < 4'hc && INSTR[7:4] < 4'hc && INSTR[11:8] == 4'h1;
    wire       modx    = INSTR_VALID && INSTR[23:17] == 7'h0a;
    wire       lea     = INSTR_VALID && INSTR[23:16] == 8'hec && INSTR[3:0] == 4'he;
    AST_NO_DMEM: assert property (!DMEM_REQ) else $error("data memory request seen");
    AST_DONE_CAUSE: assert property (OP_DONE |-> $past(INSTR_VALID))
        else $error("done without instruction");
    AST_ONE_RESULT: assert property (!(OP_DONE && OP_ILLEGAL)) else $error("done and illegal together");
    AST_IDLE_QUIET: assert property (!INSTR_VALID |=> !OP_DONE && !OP_ILLEGAL)
        else $error("pulse when idle");
    AST_SUBC_AR: assert property (modx && INSTR[2:0] == 3'h6 && !INSTR[7] |=> OP_DONE)
        else $error("sub constant on aux not done");
    AST_SUBC_BAD_T: assert property (modx && INSTR[2:0] == 3'h6 && INSTR[7] && INSTR[6]
        |=> OP_ILLEGAL && !OP_DONE) else $error("sub constant on bad temp accepted");
    AST_STACK: assert property (INSTR_VALID && INSTR[23:17] == 7'h27 |=> OP_DONE)
        else $error("stack adjust missed");
    AST_EXT_ARITH: assert property (modx && regs_ok && (INSTR[2:0] == 3'h0 || INSTR[2:0] == 3'h2)
        |=> OP_DONE) else $error("ext add or sub missed");
    AST_MOVE_Y: assert property (INSTR_VALID && INSTR[23:17] == 7'h02 && regs_ok && INSTR[3:0] == 4'h9
        |=> OP_DONE) else $error("ext move y missed");
    AST_LEA_BAD: assert property (lea && INSTR[12:9] > 4'h2 |=> OP_ILLEGAL)
        else $error("lea mode accepted");
    AST_LEA_OK: assert property (lea && INSTR[12:9] <= 4'h2 && INSTR[7:4] < 4'hc |=> OP_DONE)
        else $error("lea missed");
    AST_BHOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("bvalid dropped");
endmodule
bind addr_reg_modify_unit addr_reg_modify_unit_checker chk_u (.CLK(CLK), .ARST_N(ARST_N), .INSTR_VALID(INSTR_VALID),
    .INSTR(INSTR), .OP_DONE(OP_DONE), .OP_ILLEGAL(OP_ILLEGAL), .DMEM_REQ(DMEM_REQ),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY));
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for the address-phase modify unit
// assumes the unit, its header and the bound checker are compiled first
`include "addr_modify_regs.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, arst_n = 1'b0, iv = 1'b0, qual = 1'b0;
    logic [23:0] instr = 24'h000000;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0]  strb = 4'hf;
    logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
    wire         done, ill, awr, wrdy, bv, arr, rv;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          fails = 0;
    int          num_checks = 0;
    logic        late_b = 1'b0;
    always #10 clk = ~clk;
    addr_reg_modify_unit dut_u (.CLK(clk), .ARST_N(arst_n), .INSTR_VALID(iv), .INSTR(instr), .CIRC_QUAL(qual),
        .OP_DONE(done), .OP_ILLEGAL(ill), .DMEM_REQ(), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy));
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        fails++;
        $display("[ERR] %0t no bus answer", $time);
        test_done();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= !late_b;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
            if (bv && brdy) break;
            if (bv) brdy <= 1'b1;
        end
        brdy <= 1'b0;
        if (n == 40) hang();
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
            if (rv && rrdy) break;
        end
        rrdy <= 1'b0;
        if (n == 40) hang();
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, er});
    endtask
    // issue one word, then look at the result pulse one cycle after it is taken
    task automatic op(input logic [23:0] w, input logic q, input logic [1:0] k);
        @(posedge clk);
        iv <= 1'b1;
        instr <= w;
        qual <= q;
        @(posedge clk);
        iv <= 1'b0;
        qual <= 1'b0;
        @(posedge clk);
        chk({30'h0, ill, done}, {30'h0, k});
    endtask
    function automatic logic [23:0] ext(input logic [6:0] h, input logic [3:0] s,
                                        input logic [3:0] d, input logic [3:0] l);
        return {h, 1'b0, s, 4'h1, d, l};
    endfunction
    function automatic logic [23:0] subc(input logic [7:0] p, input logic [3:0] r, input logic [3:0] l);
        return {7'h0a, 1'b0, p, r, l};
    endfunction
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rd(8'h00, 32'h0, `RESP_OKAY);
        rd(`ADDR_CONTROL, 32'h0, `RESP_OKAY);
        wr(8'h80, 32'h1, `RESP_SLVERR);
        wr(`ADDR_LAST_RESULT, 32'h1, `RESP_SLVERR);
        rd(8'h80, 32'h0, `RESP_SLVERR);
        wr(8'h00, 32'h123456, `RESP_OKAY);
        wr(8'h04, 32'h435634, `RESP_OKAY);
        op(ext(7'h0a, 4'h0, 4'h1, 4'h0), 1'b0, 2'h1);
        rd(8'h04, 32'h558a8a, `RESP_OKAY);
        wr(8'h04, 32'h435634, `RESP_OKAY);
        op(ext(7'h0a, 4'h0, 4'h1, 4'h2), 1'b0, 2'h1);
        rd(8'h04, 32'h3121de, `RESP_OKAY);
        op(ext(7'h02, 4'h0, 4'h5, 4'h9), 1'b0, 2'h1);
        rd(8'h14, 32'h123456, `RESP_OKAY);
        wr(8'h1c, 32'h8080, `RESP_OKAY);
        wr(8'h2c, 32'h8000, `RESP_OKAY);
        op(ext(7'h0a, 4'h7, 4'hb, 4'h8), 1'b0, 2'h1);
        rd(8'h2c, 32'h10080, `RESP_OKAY);
        op(ext(7'h0a, 4'h7, 4'hb, 4'ha), 1'b0, 2'h1);
        rd(8'h2c, 32'h8000, `RESP_OKAY);
        op(ext(7'h0a, 4'h5, 4'h7, 4'h1), 1'b0, 2'h1);
        rd(8'h1c, 32'h123456, `RESP_OKAY);
        wr(8'h08, 32'h7fffff, `RESP_OKAY);
        wr(8'h0c, 32'h1, `RESP_OKAY);
        op(ext(7'h0a, 4'h3, 4'h2, 4'h0), 1'b0, 2'h1);
        rd(8'h08, 32'h0, `RESP_OKAY);
        op(ext(7'h0a, 4'h3, 4'h2, 4'h2), 1'b0, 2'h1);
        rd(8'h08, 32'h7fffff, `RESP_OKAY);
        op(ext(7'h0a, 4'h0, 4'hc, 4'h0), 1'b0, 2'h2);
        // circular buffers: low group 16, high group 32, aux 0 and 4 enabled
        wr(`ADDR_CIRC_LOW, 32'h10, `RESP_OKAY);
        late_b = 1'b1;
        wr(`ADDR_CIRC_HIGH, 32'h20, `RESP_OKAY);
        late_b = 1'b0;
        wr(`ADDR_STATUS_TWO, 32'h11, `RESP_OKAY);
        wr(8'h00, 32'h3, `RESP_OKAY);
        op(subc(8'h05, 4'h0, 4'h6), 1'b0, 2'h1);
        rd(8'h00, 32'he, `RESP_OKAY);
        wr(8'h10, 32'h2, `RESP_OKAY);
        op(subc(8'h04, 4'h4, 4'he), 1'b0, 2'h1);
        rd(8'h10, 32'h1e, `RESP_OKAY);
        wr(8'h04, 32'h3, `RESP_OKAY);
        op(subc(8'h05, 4'h1, 4'h6), 1'b1, 2'h1);
        rd(8'h04, 32'he, `RESP_OKAY);
        wr(`ADDR_CONTROL, 32'h1, `RESP_OKAY);
        wr(8'h10, 32'h2, `RESP_OKAY);
        op(subc(8'h04, 4'h4, 4'h6), 1'b0, 2'h1);
        rd(8'h10, 32'he, `RESP_OKAY);
        wr(`ADDR_CONTROL, 32'h0, `RESP_OKAY);
        wr(`ADDR_STATUS_TWO, 32'h0, `RESP_OKAY);
        wr(8'h00, 32'h10003, `RESP_OKAY);
        op(subc(8'h05, 4'h0, 4'he), 1'b0, 2'h1);
        rd(8'h00, 32'h1fffe, `RESP_OKAY);
        wr(8'h30, 32'h100, `RESP_OKAY);
        op(subc(8'hff, 4'h8, 4'h6), 1'b0, 2'h1);
        rd(8'h30, 32'h1, `RESP_OKAY);
        op(subc(8'h01, 4'hc, 4'h6), 1'b0, 2'h2);
        // stack adjust, 16-bit stack then 32-bit stack
        wr(8'h20, 32'h100, `RESP_OKAY);
        wr(8'h24, 32'h200, `RESP_OKAY);
        op({7'h27, 1'b0, 8'h80, 8'h5a}, 1'b0, 2'h1);
        rd(8'h20, 32'h80, `RESP_OKAY);
        rd(8'h24, 32'h200, `RESP_OKAY);
        wr(`ADDR_CONTROL, 32'h2, `RESP_OKAY);
        op({7'h27, 1'b1, 8'h7f, 8'h00}, 1'b0, 2'h1);
        rd(8'h20, 32'hff, `RESP_OKAY);
        rd(8'h24, 32'h27f, `RESP_OKAY);
        // effective address into extended pointers
        wr(8'h04, 32'h15678, `RESP_OKAY);
        op({8'hec, 3'h1, 4'h0, 1'b0, 4'h0, 4'he}, 1'b0, 2'h1);
        rd(8'h00, 32'h15678, `RESP_OKAY);
        wr(8'h30, 32'h10, `RESP_OKAY);
        op({8'hec, 3'h1, 4'h1, 1'b0, 4'h8, 4'he}, 1'b0, 2'h1);
        rd(8'h20, 32'h15688, `RESP_OKAY);
        op({8'hec, 3'h1, 4'h5, 1'b0, 4'h3, 4'he}, 1'b0, 2'h2);
        // circular effective address: aux 1 enabled, low group size 16, offset from T1
        wr(`ADDR_STATUS_TWO, 32'h2, `RESP_OKAY);
        wr(8'h04, 32'h1000c, `RESP_OKAY);
        wr(8'h34, 32'h6, `RESP_OKAY);
        op({8'hec, 3'h1, 4'h2, 1'b0, 4'h3, 4'he}, 1'b0, 2'h1);
        rd(8'h0c, 32'h10002, `RESP_OKAY);
        test_done();
    end
endmodule
`default_nettype wire
